// [core/tpl_pkg.sv]
// constants, types and decode helpers for the touch-probe position latch
// assumes one control clock; object indices arrive as 16-bit values
package tpl_pkg;

    localparam logic [15:0] IDX_CTRL    = 16'h60B8;
    localparam logic [15:0] IDX_STAT    = 16'h60B9;
    localparam logic [15:0] IDX_P1_RISE = 16'h60BA;
    localparam logic [15:0] IDX_P1_FALL = 16'h60BB;
    localparam logic [15:0] IDX_P2_RISE = 16'h60BC;
    localparam logic [15:0] IDX_P2_FALL = 16'h60BD;

    // per-probe field base inside the control and status words
    localparam int P1_BASE = 0;
    localparam int P2_BASE = 8;

    // control field offsets relative to the probe base
    localparam int CB_EN   = 0;
    localparam int CB_MODE = 1;
    localparam int CB_SRC  = 2;
    localparam int CB_RISE = 4;
    localparam int CB_FALL = 5;

    // status field offsets relative to the probe base
    localparam int SB_EN    = 0;
    localparam int SB_RDONE = 1;
    localparam int SB_FDONE = 2;
    localparam int SB_SRC   = 6;
    localparam int SB_LVL   = 7;

    localparam logic [15:0] CTRL_WMASK = 16'h3737;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [31:0] RDATA_ZERO = 32'h00000000;

    localparam int NUM_IN      = 3; // probe1 pin, probe2 pin, encoder index
    localparam int IN_P1       = 0;
    localparam int IN_P2       = 1;
    localparam int IN_IDX      = 2;
    localparam int SYNC_STAGES = 3;

    typedef struct packed {
        logic en;
        logic cont;
        logic src;
        logic rise_en;
        logic fall_en;
    } tpl_cfg_type;

    typedef struct packed {
        logic di_rise;
        logic di_fall;
        logic idx_rise;
    } tpl_evt_type;

    function automatic tpl_cfg_type tpl_decode_cfg(input logic [15:0] w,
                                                   input int base);
        tpl_cfg_type c;
        c.en      = w[base+CB_EN];
        c.cont    = w[base+CB_MODE];
        c.src     = w[base+CB_SRC];
        c.rise_en = w[base+CB_RISE];
        c.fall_en = w[base+CB_FALL];
        return c;
    endfunction

endpackage

// [core/tpl_probe_chan.sv]
// one probe channel: qualifies edges and latches the position feedback
// assumes event pulses are one cycle wide and on the control clock
module tpl_probe_chan #(
    parameter int POS_W = 32
) (
    input  wire logic               i_clk,       // control clock
    input  wire logic               i_arst_n,    // async reset, low
    input  tpl_pkg::tpl_cfg_type    i_cfg,       // decoded probe config
    input  tpl_pkg::tpl_evt_type    i_evt,       // filtered edge pulses
    input  wire logic [POS_W-1:0]   i_pos,       // position feedback
    output logic      [POS_W-1:0]   o_rise_pos,  // rising capture
    output logic      [POS_W-1:0]   o_fall_pos,  // falling capture
    output logic                    o_rise_done, // rising latched
    output logic                    o_fall_done  // falling latched
);

    logic rise_hit;
    logic fall_hit;

    // index falling edges never latch, so fall needs the pin source
    assign rise_hit = i_cfg.en && i_cfg.rise_en
                   && (i_cfg.src ? i_evt.idx_rise : i_evt.di_rise)
                   && (i_cfg.cont || !o_rise_done);
    assign fall_hit = i_cfg.en && i_cfg.fall_en && !i_cfg.src
                   && i_evt.di_fall
                   && (i_cfg.cont || !o_fall_done);

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rise_pos <= '0;
        end else if (rise_hit) begin
            o_rise_pos <= i_pos;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_fall_pos <= '0;
        end else if (fall_hit) begin
            o_fall_pos <= i_pos;
        end
    end

    // disabling is the only re-arm; set and clear never meet
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rise_done <= 1'b0;
            o_fall_done <= 1'b0;
        end else if (!i_cfg.en) begin
            o_rise_done <= 1'b0;
            o_fall_done <= 1'b0;
        end else begin
            o_rise_done <= o_rise_done | rise_hit;
            o_fall_done <= o_fall_done | fall_hit;
        end
    end

    AST_RISE_CAPT: assert property (@(posedge i_clk)
        disable iff (!i_arst_n)
        rise_hit |=> (o_rise_pos == $past(i_pos)) && o_rise_done)
        else $error("rising capture did not load position");

    AST_FALL_CAPT: assert property (@(posedge i_clk)
        disable iff (!i_arst_n)
        fall_hit |=> (o_fall_pos == $past(i_pos)) && o_fall_done)
        else $error("falling capture did not load position");

    AST_OFF_FROZEN: assert property (@(posedge i_clk)
        disable iff (!i_arst_n)
        !i_cfg.en |=> $stable(o_rise_pos) && $stable(o_fall_pos)
                      && !o_rise_done && !o_fall_done)
        else $error("disabled probe changed its captures");

    AST_SINGLE_HOLD: assert property (@(posedge i_clk)
        disable iff (!i_arst_n)
        (i_cfg.en && !i_cfg.cont && o_rise_done && o_fall_done)
        |=> $stable(o_rise_pos) && $stable(o_fall_pos))
        else $error("single-shot capture was overwritten");

    AST_IDX_NO_FALL: assert property (@(posedge i_clk)
        disable iff (!i_arst_n)
        i_cfg.src |=> $stable(o_fall_pos))
        else $error("index source latched a falling edge");

endmodule // tpl_probe_chan

// [core/tpl_touch_probe.sv]
// two-channel touch-probe position latch with object-index access port
// assumes probe pins and index pulse are asynchronous; position and
// object access come from logic on the same control clock
// Notes on behaviour
// - enable bits 0 and 8 arm each probe
// - mode bits 1 and 9: once or continuous
// - bit 2 picks probe one pin or index
// - bit 10 picks probe two pin or index
// - bits 4/12 rising, 5/13 falling edge enables
// - status bits 0 and 8 show enable
// - status 1/2 and 9/10 show latch done
// - status bits 6 and 14 echo source
// - status bits 7 and 15 show pin level
// - rising edge loads position into rise register
// - falling edge loads position into fall register
// - index falling edge never latches
module tpl_touch_probe #(
    parameter int POS_W = 32
) (
    input  wire logic               i_clk,                  // control clock
    input  wire logic               i_arst_n,               // async reset
    input  wire logic               i_probe1_digital_input, // probe 1 pin
    input  wire logic               i_probe2_digital_input, // probe 2 pin
    input  wire logic               i_enc_index,            // index pulse
    input  wire logic [POS_W-1:0]   i_pos_fb,               // position
    input  wire logic               i_obj_wr,               // write strobe
    input  wire logic               i_obj_rd,               // read strobe
    input  wire logic [15:0]        i_obj_index,            // object index
    input  wire logic [15:0]        i_obj_wdata,            // write data
    output logic      [31:0]        o_obj_rdata,            // read data
    output logic                    o_obj_ack,              // access done
    output logic                    o_obj_err               // bad access
);

    if (POS_W < 1 || POS_W > 32) begin : g_bad_pos_w
        $error("POS_W must lie between 1 and 32");
    end

    logic [tpl_pkg::NUM_IN-1:0] raw_in;
    logic [tpl_pkg::NUM_IN-1:0] sync1_reg;
    logic [tpl_pkg::NUM_IN-1:0] sync2_reg;
    logic [tpl_pkg::NUM_IN-1:0] sync3_reg;
    logic [tpl_pkg::NUM_IN-1:0] filt_reg;
    logic [tpl_pkg::NUM_IN-1:0] filt_prev_reg;
    logic [tpl_pkg::NUM_IN-1:0] in_rise;
    logic [tpl_pkg::NUM_IN-1:0] in_fall;

    logic [15:0]                ctrl_reg;
    logic [15:0]                stat_word;
    tpl_pkg::tpl_cfg_type       cfg1;
    tpl_pkg::tpl_cfg_type       cfg2;
    tpl_pkg::tpl_evt_type       evt1;
    tpl_pkg::tpl_evt_type       evt2;
    logic [POS_W-1:0]           p1_rise_pos;
    logic [POS_W-1:0]           p1_fall_pos;
    logic [POS_W-1:0]           p2_rise_pos;
    logic [POS_W-1:0]           p2_fall_pos;
    logic                       p1_rise_done;
    logic                       p1_fall_done;
    logic                       p2_rise_done;
    logic                       p2_fall_done;

    logic                       access;
    logic                       mapped;
    logic                       ctrl_write;
    logic                       err_next;
    logic [31:0]                rdata_next;

    assign raw_in[tpl_pkg::IN_P1]  = i_probe1_digital_input;
    assign raw_in[tpl_pkg::IN_P2]  = i_probe2_digital_input;
    assign raw_in[tpl_pkg::IN_IDX] = i_enc_index;

    // three stages; the level moves only once stages two and three agree,
    // which also rejects a single-cycle glitch on the pin
    for (genvar k = 0; k < tpl_pkg::NUM_IN; k++) begin : g_sync
        always_ff @(posedge i_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
                sync1_reg[k] <= 1'b0;
                sync2_reg[k] <= 1'b0;
                sync3_reg[k] <= 1'b0;
            end else begin
                sync1_reg[k] <= raw_in[k];
                sync2_reg[k] <= sync1_reg[k];
                sync3_reg[k] <= sync2_reg[k];
            end
        end

        always_ff @(posedge i_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
                filt_reg[k]      <= 1'b0;
                filt_prev_reg[k] <= 1'b0;
            end else begin
                if (sync2_reg[k] == sync3_reg[k]) begin
                    filt_reg[k] <= sync3_reg[k];
                end
                filt_prev_reg[k] <= filt_reg[k];
            end
        end

        assign in_rise[k] = filt_reg[k] & ~filt_prev_reg[k];
        assign in_fall[k] = ~filt_reg[k] & filt_prev_reg[k];
    end

    // control word; reserved bits never store
    assign ctrl_write = i_obj_wr && (i_obj_index == tpl_pkg::IDX_CTRL);

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl_reg <= tpl_pkg::CTRL_RESET;
        end else if (ctrl_write) begin
            ctrl_reg <= i_obj_wdata & tpl_pkg::CTRL_WMASK;
        end
    end

    assign cfg1 = tpl_pkg::tpl_decode_cfg(ctrl_reg, tpl_pkg::P1_BASE);
    assign cfg2 = tpl_pkg::tpl_decode_cfg(ctrl_reg, tpl_pkg::P2_BASE);

    // the index pulse is shared by both probes
    assign evt1.di_rise  = in_rise[tpl_pkg::IN_P1];
    assign evt1.di_fall  = in_fall[tpl_pkg::IN_P1];
    assign evt1.idx_rise = in_rise[tpl_pkg::IN_IDX];
    assign evt2.di_rise  = in_rise[tpl_pkg::IN_P2];
    assign evt2.di_fall  = in_fall[tpl_pkg::IN_P2];
    assign evt2.idx_rise = in_rise[tpl_pkg::IN_IDX];

    tpl_probe_chan #(
        .POS_W       (POS_W)
    ) u_probe1 (
        .i_clk       (i_clk),
        .i_arst_n    (i_arst_n),
        .i_cfg       (cfg1),
        .i_evt       (evt1),
        .i_pos       (i_pos_fb),
        .o_rise_pos  (p1_rise_pos),
        .o_fall_pos  (p1_fall_pos),
        .o_rise_done (p1_rise_done),
        .o_fall_done (p1_fall_done)
    );

    tpl_probe_chan #(
        .POS_W       (POS_W)
    ) u_probe2 (
        .i_clk       (i_clk),
        .i_arst_n    (i_arst_n),
        .i_cfg       (cfg2),
        .i_evt       (evt2),
        .i_pos       (i_pos_fb),
        .o_rise_pos  (p2_rise_pos),
        .o_fall_pos  (p2_fall_pos),
        .o_rise_done (p2_rise_done),
        .o_fall_done (p2_fall_done)
    );

    // status word; every bit not assigned stays zero
    always_comb begin
        stat_word = '0;
        stat_word[tpl_pkg::P1_BASE+tpl_pkg::SB_EN]    = cfg1.en;
        stat_word[tpl_pkg::P1_BASE+tpl_pkg::SB_RDONE] = p1_rise_done;
        stat_word[tpl_pkg::P1_BASE+tpl_pkg::SB_FDONE] = p1_fall_done;
        stat_word[tpl_pkg::P1_BASE+tpl_pkg::SB_SRC]   = cfg1.src;
        stat_word[tpl_pkg::P1_BASE+tpl_pkg::SB_LVL]   =
            filt_reg[tpl_pkg::IN_P1];
        stat_word[tpl_pkg::P2_BASE+tpl_pkg::SB_EN]    = cfg2.en;
        stat_word[tpl_pkg::P2_BASE+tpl_pkg::SB_RDONE] = p2_rise_done;
        stat_word[tpl_pkg::P2_BASE+tpl_pkg::SB_FDONE] = p2_fall_done;
        stat_word[tpl_pkg::P2_BASE+tpl_pkg::SB_SRC]   = cfg2.src;
        stat_word[tpl_pkg::P2_BASE+tpl_pkg::SB_LVL]   =
            filt_reg[tpl_pkg::IN_P2];
    end

    // object access: answer registered one edge after the strobe
    assign access = i_obj_wr || i_obj_rd;

    always_comb begin
        mapped     = 1'b1;
        rdata_next = tpl_pkg::RDATA_ZERO;
        case (i_obj_index)
            tpl_pkg::IDX_CTRL:    rdata_next[15:0]      = ctrl_reg;
            tpl_pkg::IDX_STAT:    rdata_next[15:0]      = stat_word;
            tpl_pkg::IDX_P1_RISE: rdata_next[POS_W-1:0] = p1_rise_pos;
            tpl_pkg::IDX_P1_FALL: rdata_next[POS_W-1:0] = p1_fall_pos;
            tpl_pkg::IDX_P2_RISE: rdata_next[POS_W-1:0] = p2_rise_pos;
            tpl_pkg::IDX_P2_FALL: rdata_next[POS_W-1:0] = p2_fall_pos;
            default:              mapped                = 1'b0;
        endcase
        // status and captures are read-only, so a write there is refused
        err_next = !mapped || (i_obj_wr && !ctrl_write);
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_obj_ack <= 1'b0;
            o_obj_err <= 1'b0;
        end else begin
            o_obj_ack <= access;
            o_obj_err <= access && err_next;
        end
    end

    // read data holds its last value between reads
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_obj_rdata <= tpl_pkg::RDATA_ZERO;
        end else if (i_obj_rd && !i_obj_wr) begin
            o_obj_rdata <= mapped ? rdata_next : tpl_pkg::RDATA_ZERO;
        end
    end

    AST_CTRL_WRITE: assert property (@(posedge i_clk)
        disable iff (!i_arst_n)
        ctrl_write |=> ctrl_reg == ($past(i_obj_wdata) & 16'h3737))
        else $error("control write not stored with reserved bits masked");

    AST_STAT_EN: assert property (@(posedge i_clk)
        disable iff (!i_arst_n)
        stat_word[0] == ctrl_reg[0] && stat_word[8] == ctrl_reg[8])
        else $error("status enable bits do not follow control");

    AST_STAT_SRC: assert property (@(posedge i_clk)
        disable iff (!i_arst_n)
        stat_word[6] == ctrl_reg[2] && stat_word[14] == ctrl_reg[10])
        else $error("status source bits do not echo control");

    AST_STAT_RSVD: assert property (@(posedge i_clk)
        disable iff (!i_arst_n)
        (stat_word & 16'h3838) == 16'h0000)
        else $error("reserved status bit set");

    AST_LEVEL: assert property (@(posedge i_clk)
        disable iff (!i_arst_n)
        (sync2_reg[0] == sync3_reg[0]) |=> stat_word[7] == $past(sync3_reg[0]))
        else $error("probe one level not reported");

    AST_STAT_READ: assert property (@(posedge i_clk)
        disable iff (!i_arst_n)
        (i_obj_rd && !i_obj_wr && i_obj_index == 16'h60B9)
        |=> o_obj_ack && o_obj_rdata == {16'h0000, $past(stat_word)})
        else $error("status read returned wrong word");

    AST_ACK_ONCE: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        !access |=> !o_obj_ack && !o_obj_err)
        else $error("answer without a request");

    AST_REARM: assert property (@(posedge i_clk)
        disable iff (!i_arst_n)
        (ctrl_write && i_obj_wdata == 16'h0000)
        |=> ##1 stat_word[1] == 1'b0 && stat_word[2] == 1'b0
                && stat_word[9] == 1'b0 && stat_word[10] == 1'b0)
        else $error("zero write did not clear latch flags");

    AST_P2_INDEX: assert property (@(posedge i_clk)
        disable iff (!i_arst_n)
        (cfg2.en && cfg2.src && cfg2.rise_en && cfg2.cont
         && in_rise[tpl_pkg::IN_IDX])
        |=> p2_rise_pos == $past(i_pos_fb))
        else $error("probe two did not latch on index");

    AST_LEVEL2: assert property (@(posedge i_clk)
        disable iff (!i_arst_n)
        (sync2_reg[tpl_pkg::IN_P2] == sync3_reg[tpl_pkg::IN_P2])
        |=> stat_word[15] == $past(sync3_reg[tpl_pkg::IN_P2]))
        else $error("probe two level not reported");

    AST_P1_INDEX: assert property (@(posedge i_clk)
        disable iff (!i_arst_n)
        (cfg1.en && cfg1.src && cfg1.rise_en && cfg1.cont
         && in_rise[tpl_pkg::IN_IDX])
        |=> p1_rise_pos == $past(i_pos_fb))
        else $error("probe one did not latch on index");

    AST_P1_PIN_IGN: assert property (@(posedge i_clk)
        disable iff (!i_arst_n)
        (cfg1.src && !in_rise[tpl_pkg::IN_IDX]) |=> $stable(p1_rise_pos))
        else $error("probe one latched its pin with index source");

    AST_P2_PIN_IGN: assert property (@(posedge i_clk)
        disable iff (!i_arst_n)
        (cfg2.src && !in_rise[tpl_pkg::IN_IDX]) |=> $stable(p2_rise_pos))
        else $error("probe two latched its pin with index source");

    AST_P1_RISE_OFF: assert property (@(posedge i_clk)
        disable iff (!i_arst_n)
        !cfg1.rise_en |=> $stable(p1_rise_pos))
        else $error("probe one latched a disabled rising edge");

    AST_P1_FALL_OFF: assert property (@(posedge i_clk)
        disable iff (!i_arst_n)
        !cfg1.fall_en |=> $stable(p1_fall_pos))
        else $error("probe one latched a disabled falling edge");

    AST_P2_FALL_OFF: assert property (@(posedge i_clk)
        disable iff (!i_arst_n)
        !cfg2.fall_en |=> $stable(p2_fall_pos))
        else $error("probe two latched a disabled falling edge");

    AST_P2_CONT: assert property (@(posedge i_clk)
        disable iff (!i_arst_n)
        (cfg2.en && cfg2.cont && cfg2.rise_en && !cfg2.src
         && in_rise[tpl_pkg::IN_P2])
        |=> p2_rise_pos == $past(i_pos_fb) && p2_rise_done)
        else $error("continuous probe two missed a rising edge");

endmodule // tpl_touch_probe

// [verification/tpl_master_model.sv]
// fieldbus master model: one-word object accesses on the drive's port
// assumes the bench calls one task at a time from a single process
module tpl_master_model (
    input  wire logic        i_clk,       // control clock
    input  wire logic [31:0] i_obj_rdata, // read data
    input  wire logic        i_obj_ack,   // access done
    input  wire logic        i_obj_err,   // refused access
    output logic             o_obj_wr,    // write strobe
    output logic             o_obj_rd,    // read strobe
    output logic [15:0]      o_obj_index, // object index
    output logic [15:0]      o_obj_wdata  // write data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_obj_wr    = 1'b0;
        o_obj_rd    = 1'b0;
        o_obj_index = 16'h0000;
        o_obj_wdata = 16'h0000;
    end

    // gap idles the master first, so prompt and slow masters both occur
    task automatic obj_access(input logic wr, input logic [15:0] idx,
                              input logic [15:0] wd, input int gap,
                              output logic [31:0] rdat, output logic err,
                              output logic ok);
        ok = 1'b0;
        rdat = 32'h00000000;
        err = 1'b0;
        repeat (gap) @(posedge i_clk);
        @(posedge i_clk);
        o_obj_wr    <= wr;
        o_obj_rd    <= ~wr;
        o_obj_index <= idx;
        o_obj_wdata <= wd;
        @(posedge i_clk);
        o_obj_wr <= 1'b0;
        o_obj_rd <= 1'b0;
        for (int n = 0; n < 4 && !ok; n++) begin
            @(negedge i_clk);
            if (i_obj_ack === 1'b1) begin
                ok = 1'b1;
                rdat = i_obj_rdata;
                err = i_obj_err;
            end
        end
        @(posedge i_clk);
        // released lines show the inverse so a stale copy never helps
        o_obj_index <= ~idx;
        o_obj_wdata <= ~wd;
    endtask

    task automatic rearm(input logic [15:0] cfg, output logic ok);
        logic [31:0] d;
        logic        e;
        logic        ok0;
        obj_access(1'b1, tpl_pkg::IDX_CTRL, 16'h0000, 0, d, e, ok0);
        obj_access(1'b1, tpl_pkg::IDX_CTRL, cfg, 2, d, e, ok);
        ok = ok & ok0;
    endtask
endmodule // tpl_master_model

// [verification/touch_probe_position_latch_bench.sv]
// self-checking bench for the two-channel touch-probe position latch
// assumes the master model file is compiled first
module touch_probe_position_latch_bench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [15:0] CTL = tpl_pkg::IDX_CTRL;
    localparam logic [15:0] STA = tpl_pkg::IDX_STAT;
    localparam logic [15:0] P1R = tpl_pkg::IDX_P1_RISE;
    localparam logic [15:0] P1F = tpl_pkg::IDX_P1_FALL;
    localparam logic [15:0] P2R = tpl_pkg::IDX_P2_RISE;
    localparam logic [15:0] P2F = tpl_pkg::IDX_P2_FALL;

    logic        clk;
    logic        arst_n;
    logic [2:0]  pins; // probe1 pin, probe2 pin, index
    logic [31:0] pos;
    logic        wr;
    logic        rd;
    logic [15:0] idx;
    logic [15:0] wdata;
    logic [31:0] rdata;
    logic        ack;
    logic        err;
    int          fail_count;
    int          checks_done;

    always #5 clk = ~clk;

    tpl_touch_probe #(.POS_W(32)) i_dut (
        .i_clk(clk), .i_arst_n(arst_n),
        .i_probe1_digital_input(pins[0]), .i_probe2_digital_input(pins[1]),
        .i_enc_index(pins[2]), .i_pos_fb(pos), .i_obj_wr(wr),
        .i_obj_rd(rd), .i_obj_index(idx), .i_obj_wdata(wdata),
        .o_obj_rdata(rdata), .o_obj_ack(ack), .o_obj_err(err));

    tpl_master_model i_master (
        .i_clk(clk), .i_obj_rdata(rdata), .i_obj_ack(ack),
        .i_obj_err(err), .o_obj_wr(wr), .o_obj_rd(rd),
        .o_obj_index(idx), .o_obj_wdata(wdata));

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask

    task automatic acc(input logic w, input logic [15:0] ix,
                       input logic [15:0] wd, output logic [31:0] d,
                       output logic e);
        logic ok;
        i_master.obj_access(w, ix, wd, 1, d, e, ok);
        chk("ack", 32'h1, {31'h0, ok});
        if (ok !== 1'b1) begin
            finish_test();
        end
    endtask

    task automatic rd_chk(input logic [15:0] ix, input logic [31:0] exp,
                          input string what);
        logic [31:0] d;
        logic        e;
        acc(1'b0, ix, 16'h0000, d, e);
        chk(what, exp, d);
        chk({what, " err"}, 32'h0, {31'h0, e});
    endtask

    task automatic wr_ctrl(input logic [15:0] v);
        logic [31:0] d;
        logic        e;
        acc(1'b1, CTL, v, d, e);
    endtask

    // holds the level well past the input filter before anyone reads
    task automatic pin(input int k, input logic v, input logic [31:0] p);
        @(posedge clk);
        pos     <= p;
        pins[k] <= v;
        repeat (8) @(posedge clk);
    endtask

    task automatic t_reset();
        logic [31:0] d;
        logic        e;
        rd_chk(CTL, 32'h0, "ctrl reset");
        rd_chk(STA, 32'h0, "status reset");
        rd_chk(P2F, 32'h0, "p2 fall reset");
        acc(1'b0, 16'h60BE, 16'h0000, d, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        acc(1'b1, STA, 16'hFFFF, d, e);
        chk("status write err", 32'h1, {31'h0, e});
        rd_chk(STA, 32'h0, "status after write");
        $display("test reset done");
    endtask

    task automatic t_reserved();
        wr_ctrl(16'hFFFF);
        rd_chk(CTL, 32'h3737, "ctrl mask");
        rd_chk(STA, 32'h4141, "status en src");
        wr_ctrl(16'h0000);
        rd_chk(STA, 32'h0, "status off");
        $display("test reserved done");
    endtask

    task automatic t_once();
        logic ok;
        wr_ctrl(16'h0031);
        pin(0, 1'b1, 32'h11111111);
        rd_chk(P1R, 32'h11111111, "p1 rise pos");
        rd_chk(STA, 32'h83, "p1 rise status");
        pin(0, 1'b0, 32'h22222222);
        rd_chk(P1F, 32'h22222222, "p1 fall pos");
        rd_chk(STA, 32'h07, "p1 both done");
        pin(0, 1'b1, 32'h33333333);
        rd_chk(P1R, 32'h11111111, "p1 rise held");
        i_master.rearm(16'h0031, ok);
        chk("rearm ack", 32'h1, {31'h0, ok});
        pin(0, 1'b0, 32'h44444444);
        rd_chk(P1F, 32'h44444444, "p1 fall rearmed");
        rd_chk(STA, 32'h05, "p1 rearm status");
        $display("test single shot done");
    endtask

    task automatic t_cont();
        wr_ctrl(16'h0000);
        wr_ctrl(16'h1300);
        pin(1, 1'b1, 32'hA5A50001);
        rd_chk(P2R, 32'hA5A50001, "p2 rise pos");
        pin(1, 1'b0, 32'hA5A50002);
        rd_chk(P2F, 32'h0, "p2 fall off");
        pin(1, 1'b1, 32'hA5A50003);
        rd_chk(P2R, 32'hA5A50003, "p2 rise again");
        rd_chk(STA, 32'h8300, "p2 rise status");
        wr_ctrl(16'h3300);
        pin(1, 1'b0, 32'h80000000);
        rd_chk(P2F, 32'h80000000, "p2 fall pos");
        rd_chk(STA, 32'h0700, "p2 status");
        $display("test continuous done");
    endtask

    task automatic t_index();
        wr_ctrl(16'h0000);
        wr_ctrl(16'h3737);
        pin(2, 1'b1, 32'h0000BEEF);
        rd_chk(P1R, 32'h0000BEEF, "idx p1 rise");
        rd_chk(P2R, 32'h0000BEEF, "idx p2 rise");
        pin(2, 1'b0, 32'h0000CAFE);
        rd_chk(P1F, 32'h44444444, "idx p1 fall");
        rd_chk(P2F, 32'h80000000, "idx p2 fall");
        pin(0, 1'b1, 32'h0000F00D);
        pin(0, 1'b0, 32'h0000F00D);
        rd_chk(P1R, 32'h0000BEEF, "pin ignored");
        rd_chk(STA, 32'h4343, "idx status");
        $display("test index done");
    endtask

    task automatic t_off();
        wr_ctrl(16'h3030);
        pin(0, 1'b1, 32'h12345678);
        pin(1, 1'b1, 32'h12345678);
        rd_chk(P1R, 32'h0000BEEF, "p1 disabled");
        rd_chk(P2R, 32'h0000BEEF, "p2 disabled");
        rd_chk(STA, 32'h8080, "levels only");
        $display("test disabled done");
    endtask

    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        pins = 3'h0;
        pos = 32'h0;
        fail_count = 0;
        checks_done = 0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_reserved();
        t_once();
        t_cont();
        t_index();
        t_off();
        finish_test();
    end
endmodule // touch_probe_position_latch_bench
